// *** tb/fp_requester.sv ***
// Purpose: Issue side presenting floating-point operations
// Assumes: send is called at a falling clock edge
// Notes:   A refused op must be re-presented by the caller
`default_nettype none
module fp_requester (
  input  wire logic       clk,
  input  wire logic       fp_issued,
  output var  logic       fp_valid,
  output var  logic [2:0] fp_class,
  output var  logic [4:0] fp_dst,
  output var  logic [4:0] fp_src_a
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {fp_valid, fp_class, fp_dst, fp_src_a} = 14'h0;
  // Present for one cycle, then report whether it was taken
  task automatic send(input logic [2:0] c, input logic [4:0] s,
                      output logic ok);
    fp_valid = 1'b1;
    fp_class = c;
    fp_dst = {2'h0, c} + 5'h1;
    fp_src_a = s;
    @(negedge clk);
    fp_valid = 1'b0;
    ok = fp_issued;
  endtask
endmodule
`default_nettype wire

// *** tb/issue_timing_assertions.sv ***
// Purpose: Port timing checks for issue_timing
// Assumes: ce held high by the bench
// Notes:   Bound into every issue_timing
`default_nettype none
module issue_timing_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ld_valid,
  input wire logic       st_valid,
  input wire logic       ld_sign_ext,
  input wire logic       nxt_alu_use,
  input wire logic       nxt_addr_use,
  input wire logic [2:0] ea_low,
  input wire logic [3:0] acc_size,
  input wire logic [2:0] fp_class,
  input wire logic       fp_issued,
  input wire logic       cr_ready,
  input wire logic       fwd_from_cache,
  input wire logic       fwd_from_mem,
  input wire logic       a_hold,
  input wire logic       x_stall,
  input wire logic       second_flow
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted load and doubleword crossing
  wire logic go = ld_valid && !a_hold;
  wire logic mis = ({1'b0, ea_low} + acc_size) > 4'h8;
  chk_aln_free: assert property (
    go && !mis && !ld_sign_ext |=> fwd_from_cache && !a_hold)
    else $error("aligned load slowed");
  chk_sx_late: assert property (
    go && ld_sign_ext && !mis |=> !fwd_from_cache ##1 fwd_from_mem)
    else $error("sign load forwarded early");
  chk_sx_rate: assert property (
    go && ld_sign_ext && !mis && !nxt_addr_use |=> !a_hold)
    else $error("sign load held");
  chk_sx_addr: assert property (
    go && ld_sign_ext && !mis && nxt_addr_use |=> a_hold ##1 !a_hold)
    else $error("sign address hold wrong");
  chk_mis_addr: assert property (
    go && mis && nxt_addr_use |=> a_hold [*2])
    else $error("misaligned address hold short");
  chk_mis_flow: assert property (
    go && mis |=> second_flow && a_hold)
    else $error("no second flow");
  chk_alu_stall: assert property (
    go && (ld_sign_ext || mis) && nxt_alu_use |=> x_stall)
    else $error("no alu stall");
  chk_st_hold: assert property (
    st_valid && !a_hold && mis |=> a_hold [*2])
    else $error("store hold short");
  chk_cmp_ready: assert property (
    fp_issued && $past(fp_class) == 3'h4 |-> ##3 cr_ready)
    else $error("flags late");
  chk_dmul_gap: assert property (
    fp_issued && $past(fp_class) == 3'h1 |=> !fp_issued)
    else $error("double multiply spacing");
endmodule
bind issue_timing issue_timing_chk chk (.*);
`default_nettype wire

// *** tb/issue_timing_tb_top.sv ***
// Purpose: Directed scenarios for issue_timing
// Assumes: Inputs change on the falling clock edge
// Notes:   Divide gaps are checked here only; address-use holds here and by the checker
`default_nettype none
module issue_timing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ld_valid = 1'b0;
  logic       st_valid = 1'b0;
  logic       ld_sign_ext = 1'b0;
  logic       nxt_alu_use = 1'b0;
  logic       nxt_addr_use = 1'b0;
  logic       fp_worst = 1'b0;
  logic       fp_issue_ok;
  logic [2:0] ea_low = 3'h0;
  logic [3:0] acc_size = 4'h1;
  logic [2:0] fp_class;
  logic [4:0] fp_dst, fp_src_a;
  logic       fp_valid, fp_issued, cr_ready, second_store_data;
  logic       fwd_from_cache, fwd_from_mem, a_hold, x_stall, second_flow;
  int         error_cnt = 0;
  int         checked = 0;
  // Core clock, 5 ns period
  always #2.5 clk = ~clk;
  fp_requester fp (.clk, .fp_issued, .fp_valid, .fp_class, .fp_dst,
                   .fp_src_a);
  issue_timing uut (.clk, .rst, .ce(1'b1), .ld_valid, .st_valid,
    .ld_sign_ext, .ea_low, .acc_size, .nxt_addr_use, .nxt_alu_use,
    .fp_valid, .fp_class, .fp_worst, .fp_dst, .fp_src_a,
    .fp_src_b(5'h0), .fp_src_c(5'h0), .fwd_from_cache, .fwd_from_mem,
    .a_hold, .x_stall, .second_flow, .second_store_data,
    .fp_issue_ok, .fp_issued, .cr_ready);
  task automatic check(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  // One memory op after idle cycles; returns one cycle later
  task automatic mem(input logic l, s, x, u, input logic [2:0] e,
                     input logic [3:0] z);
    repeat (3) @(negedge clk);
    {ld_valid, st_valid, ld_sign_ext, nxt_alu_use} = {l, s, x, u};
    {ea_low, acc_size} = {e, z};
    @(negedge clk);
    {ld_valid, st_valid} = 2'h0;
  endtask
  task automatic t_fp;
    logic ok;
    fp.send(3'h1, 5'h0, ok);
    check("dmul issue", 1'b1, ok);
    fp.send(3'h0, 5'h0, ok);
    check("gap refusal", 1'b0, ok);
    fp.send(3'h0, 5'h0, ok);
    check("simple issue", 1'b1, ok);
    fp.send(3'h0, 5'h1, ok);
    check("dependent refusal", 1'b0, ok);
    fp.send(3'h4, 5'h0, ok);
    check("compare issue", 1'b1, ok);
    repeat (3) @(negedge clk);
    check("cr_ready", 1'b1, cr_ready);
    $display("test fp done");
  endtask
  // A divide, then simple ops until one is taken
  task automatic t_div(input logic [2:0] c, input logic w, input int gap);
    logic ok;
    logic hint;
    int   n;
    fp_worst = w;
    fp.send(c, 5'h0, ok);
    check("divide issue", 1'b1, ok);
    n = 0;
    hint = 1'b0;
    ok = 1'b0;
    while (!ok && n < 200)
    begin
      fp.send(3'h0, 5'h0, ok);
      if (!ok)
      begin
        n++;
        hint = fp_issue_ok;
      end
    end
    fp_worst = 1'b0;
    checked++;
    if (n != gap - 1)
    begin
      error_cnt++;
      $display("wrong value divide gap expected %0d seen %0d", gap - 1, n);
    end
    check("issue hint", 1'b1, hint);
    $display("test divide done");
  endtask
  // Loads whose result the next instruction uses as an address
  task automatic t_addr;
    nxt_addr_use = 1'b1;
    mem(1, 0, 1, 0, 3'h0, 4'h2);
    check("sign addr hold", 1'b1, a_hold);
    @(negedge clk);
    check("sign addr release", 1'b0, a_hold);
    mem(1, 0, 0, 0, 3'h6, 4'h4);
    check("mis addr hold", 1'b1, a_hold);
    @(negedge clk);
    check("mis addr wait", 1'b1, a_hold);
    @(negedge clk);
    check("mis addr release", 1'b0, a_hold);
    nxt_addr_use = 1'b0;
    $display("test address use done");
  endtask
  task automatic t_loads;
    mem(1, 0, 0, 0, 3'h4, 4'h4);
    check("aligned fwd", 1'b1, fwd_from_cache);
    mem(1, 0, 1, 1, 3'h0, 4'h2);
    check("sign stall", 1'b1, x_stall);
    check("sign hold", 1'b0, a_hold);
    @(negedge clk);
    check("sign fwd", 1'b1, fwd_from_mem);
    mem(1, 0, 0, 0, 3'h6, 4'h4);
    check("mis flow", 1'b1, second_flow);
    @(negedge clk);
    check("mis release", 1'b0, a_hold);
    $display("test loads done");
  endtask
  task automatic t_store;
    mem(0, 1, 0, 0, 3'h7, 4'h2);
    check("store hold", 1'b1, a_hold);
    check("store data", 1'b1, second_store_data);
    @(negedge clk);
    check("store extra", 1'b1, a_hold);
    $display("test store done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Reset, then the scenarios
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_fp();
    t_loads();
    t_store();
    t_div(3'h2, 1'b0, 34);
    t_div(3'h3, 1'b1, 66);
    t_addr();
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/issue_timing.v ***
// Purpose: Issue and stall timing for loads and floating-point operations
// Assumes: Decoded instruction info arrives on clk, one candidate per cycle
// Notes:   Outputs are registered and describe the next cycle's holds
// Contract
// RL1 - Ordinary loads forward from cache stage
// RL2 - Sign-extending loads forward one cycle later
// RL3 - Sign-extending loads issue every cycle, no stall
// RL4 - ALU use of sign-extended load stalls one
// RL5 - Address use of sign-extended load holds A
// RL6 - Only doubleword-crossing accesses count as misaligned
// RL7 - Misaligned load uses two A cycles
// RL8 - ALU use of misaligned load stalls one
// RL9 - Address use of misaligned load waits M end
// RL10 - Misaligned store makes two accesses, two M
// RL11 - Misaligned store adds one A cycle; code adds two (MIS_ST_A_EXTRA)
// RL12 - Simple FP ops: bandwidth 1, latency 4
// RL13 - Double multiply ops: bandwidth 2, latency 5
// RL14 - Double divide: 34/35 or 140/141 cycles
// RL15 - Single divide: 20/21 or 66/67 cycles
// RL16 - FP compares every cycle, branch after 4
// RL17 - Enforce bandwidth before next FP issue
// RL18 - Dependent FP waits for producer latency
// RL19 - Only address dependencies split issue groups
// RL20 - Detect crossing from address bits and size
// RL21 - Countdown scoreboard per FP destination register
`include "issue_timing_defs.vh"
`default_nettype none
module issue_timing (
  input  wire       clk,
  input  wire       rst,
  input  wire       ce,
  input  wire       ld_valid,
  input  wire       st_valid,
  input  wire       ld_sign_ext,
  input  wire [2:0] ea_low,
  input  wire [3:0] acc_size,
  input  wire       nxt_addr_use,
  input  wire       nxt_alu_use,
  input  wire       fp_valid,
  input  wire [2:0] fp_class,
  input  wire       fp_worst,
  input  wire [4:0] fp_dst,
  input  wire [4:0] fp_src_a,
  input  wire [4:0] fp_src_b,
  input  wire [4:0] fp_src_c,
  output reg        fwd_from_cache,
  output reg        fwd_from_mem,
  output reg        a_hold,
  output reg        x_stall,
  output reg        second_flow,
  output reg        second_store_data,
  output reg        fp_issue_ok,
  output reg        fp_issued,
  output reg        cr_ready
);

  // Per-register result countdowns, read by register number
  wire [7:0] ready_cnt [0:31];
  // Issue spacing and compare flag countdowns
  reg  [7:0] busy_cnt;
  reg  [7:0] cmp_cnt;
  // Extra address-stage cycles still owed by the access in A
  reg  [1:0] a_cnt;
  // Sign-extended or misaligned load one cycle from its result
  reg        late_ld;
  // Decoded views of the current candidates
  wire       misaligned;
  wire       mem_acc;
  wire       late_kind;
  wire       a_free;
  wire       src_busy;
  wire       fp_go;
  wire       cmp_go;
  // Next-state values from the combinational blocks
  reg  [7:0] next_bw;
  reg  [7:0] next_lat;
  reg  [1:0] next_a;
  reg  [7:0] next_busy;
  reg  [7:0] next_cmp;

  // Crossing test: last byte lands in next doubleword
  // Sum fits four bits: offset at most 7, size at most 8
  assign misaligned = ({1'b0, ea_low} + acc_size) > `DW_BYTES; // RL20 RL6
  // Any load or store presented to the address stage
  assign mem_acc = ld_valid | st_valid;
  // Loads whose result cannot leave the cache stage
  assign late_kind = ld_valid & (ld_sign_ext | misaligned);
  // No earlier access still owes address-stage cycles
  assign a_free = (a_cnt == 2'h0);

  // A source register still counting down blocks issue
  assign src_busy = (ready_cnt[fp_src_a] != 8'h00) |
                    (ready_cnt[fp_src_b] != 8'h00) |
                    (ready_cnt[fp_src_c] != 8'h00); // RL18
  // Spacing counter clear and every source ready
  assign fp_go = fp_valid & (busy_cnt == 8'h00) & ~src_busy; // RL17
  // Only compares start the flag countdown
  assign cmp_go = fp_go & (fp_class == `FC_CMP);

  // Bandwidth and latency lookup per operation class
  // Unknown class codes fall back to the simple timing
  always @*
  begin
    next_bw = `BW_SIMPLE; // RL12
    next_lat = `LAT_SIMPLE;
    case (fp_class)
      `FC_DMUL:
      begin
        next_bw = `BW_DMUL; // RL13
        next_lat = `LAT_DMUL;
      end
      `FC_DDIV:
      begin
        next_bw = fp_worst ? `BW_DDIV_WC : `BW_DDIV_TYP; // RL14
        next_lat = fp_worst ? `LAT_DDIV_WC : `LAT_DDIV_TYP;
      end
      `FC_SDIV:
      begin
        next_bw = fp_worst ? `BW_SDIV_WC : `BW_SDIV_TYP; // RL15
        next_lat = fp_worst ? `LAT_SDIV_WC : `LAT_SDIV_TYP;
      end
      `FC_CMP:
      begin
        next_bw = `BW_CMP; // RL16
        next_lat = `LAT_CMP;
      end
      default:
      begin
        next_bw = `BW_SIMPLE;
        next_lat = `LAT_SIMPLE;
      end
    endcase
  end

  // Extra address-stage cycles owed by the access in A
  // A busy A stage ignores new penalties until it drains
  always @*
  begin
    next_a = 2'h0;
    if (a_cnt != 2'h0)
      next_a = a_cnt - `ONE2;
    else if (ld_valid & misaligned)
      next_a = nxt_addr_use ? `MIS_LD_ADDR_HLD : `MIS_LD_A_EXTRA; // RL7 RL9
    else if (st_valid & misaligned)
      next_a = `MIS_ST_A_EXTRA; // RL10 RL11
    else if (ld_valid & ld_sign_ext & nxt_addr_use)
      next_a = `ALG_ADDR_HLD; // RL5
  end

  // Spacing counter: reload on issue, else count down
  always @*
  begin
    next_busy = busy_cnt;
    if (fp_go)
      next_busy = next_bw - `ONE8; // RL17
    else if (busy_cnt != 8'h00)
      next_busy = busy_cnt - `ONE8;
  end

  // Flag countdown: reload on compare issue, else count down
  always @*
  begin
    next_cmp = cmp_cnt;
    if (cmp_go)
      next_cmp = `LAT_CMP - `ONE8; // RL16
    else if (cmp_cnt != 8'h00)
      next_cmp = cmp_cnt - `ONE8;
  end

  // Scoreboard entries, one countdown per FP register
  // The issue edge itself is the first latency cycle,
  // so an entry loads one less than the latency
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : sb
      reg [7:0] cnt;
      assign ready_cnt[g] = cnt;
      always @(posedge clk or posedge rst)
      begin
        if (rst)
          cnt <= 8'h00;
        else if (ce)
        begin
          if (fp_go && fp_dst == g)
            cnt <= next_lat - `ONE8; // RL21 RL18
          else if (cnt != 8'h00)
            cnt <= cnt - `ONE8;
        end
      end
    end
  endgenerate

  // Spacing and flag counters
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_cnt <= 8'h00;
      cmp_cnt <= 8'h00;
    end
    else if (ce)
    begin
      busy_cnt <= next_busy;
      cmp_cnt <= next_cmp;
    end
  end

  // FP issue report and spacing hint
  // The hint looks one cycle ahead of the spacing counter
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fp_issue_ok <= 1'b0;
      fp_issued <= 1'b0;
    end
    else if (ce)
    begin
      fp_issue_ok <= (busy_cnt <= `ONE8) & ~fp_go; // RL17
      fp_issued <= fp_go;
    end
  end

  // Compare flags resolvable as the countdown ends
  // Compares add no issue spacing; flag users and readers of fp_dst wait
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      cr_ready <= 1'b0;
    else if (ce)
      cr_ready <= (cmp_cnt == `ONE8); // RL16
  end

  // Address-stage hold for the extra cycles owed
  // Held whenever the next count is still nonzero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      a_cnt <= 2'h0;
      a_hold <= 1'b0;
    end
    else if (ce)
    begin
      a_cnt <= next_a;
      a_hold <= (next_a != 2'h0); // RL7 RL11
    end
  end

  // Second cache access flow of a misaligned access
  // Only an access that starts with a free A stage counts
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      second_flow <= 1'b0;
    else if (ce)
      second_flow <= a_free & mem_acc & misaligned; // RL7 RL10
  end

  // Second store-data write of a misaligned store
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      second_store_data <= 1'b0;
    else if (ce)
      second_store_data <= a_free & st_valid & misaligned; // RL10
  end

  // Late load marker, one cycle ahead of its result
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      late_ld <= 1'b0;
    else if (ce)
      late_ld <= late_kind;
  end

  // Plain loads forward from the cache stage
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      fwd_from_cache <= 1'b0;
    else if (ce)
      fwd_from_cache <= ld_valid & ~ld_sign_ext & ~misaligned; // RL1
  end

  // Late loads forward one stage later
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      fwd_from_mem <= 1'b0;
    else if (ce)
      fwd_from_mem <= late_ld; // RL2 RL3
  end

  // ALU slot slides a stage, so data use never splits a group
  // The stall is flagged in the cycle after the load is seen
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      x_stall <= 1'b0;
    else if (ce)
      x_stall <= late_kind & nxt_alu_use; // RL4 RL8 RL19
  end
endmodule
`default_nettype wire

// *** verilog/issue_timing_defs.vh ***
// Purpose: Constants for load penalty and floating-point issue timing
// Assumes: Included by issue_timing.v only
// Notes:   Cycle figures are whole core cycles at 200 MHz
`ifndef ISSUE_TIMING_DEFS_VH
`define ISSUE_TIMING_DEFS_VH
// Doubleword boundary and address offset width
`define DW_BYTES        4'h8
`define DW_OFS_W        3
// Floating-point operation classes
`define FC_SIMPLE       3'h0
`define FC_DMUL         3'h1
`define FC_DDIV         3'h2
`define FC_SDIV         3'h3
`define FC_CMP          3'h4
// Bandwidth (issue spacing) and latency in cycles
`define BW_SIMPLE       8'h01
`define LAT_SIMPLE      8'h04
`define BW_DMUL         8'h02
`define LAT_DMUL        8'h05
`define BW_DDIV_TYP     8'h22
`define LAT_DDIV_TYP    8'h23
`define BW_DDIV_WC      8'h8C
`define LAT_DDIV_WC     8'h8D
`define BW_SDIV_TYP     8'h14
`define LAT_SDIV_TYP    8'h15
`define BW_SDIV_WC      8'h42
`define LAT_SDIV_WC     8'h43
`define BW_CMP          8'h01
`define LAT_CMP         8'h04
// Load penalty cycles and one-count decrement constants
`define MIS_LD_A_EXTRA  2'h1
`define MIS_ST_A_EXTRA  2'h2
`define MIS_LD_ADDR_HLD 2'h2
`define ALG_ADDR_HLD    2'h1
`define ONE8            8'h01
`define ONE2            2'h1
`endif
